// ---- hdl/ipr_ahb_front.sv ----
// AHB-Lite address decode and data-phase write tracking for the priority bank
`timescale 1ns/1ps
`include "ipr_defines.svh"
module ipr_ahb_front import ipr_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic        hready_in,
  ipr_regs_if.front        bus
);

  logic     addr_ok;
  logic     hit;
  ipr_idx_t idx;
  logic     wr_pend;
  ipr_idx_t wr_idx_q;

  // --------------------------------------------------------------------------
  // Address phase decode
  // --------------------------------------------------------------------------
  // Only NONSEQ/SEQ with hready are real transfers; BUSY and IDLE are ignored
  assign addr_ok = hsel_in && htrans_in[1] && hready_in;
  assign idx     = haddr_in[4:2];
  // Word aligned, inside the six-word window; anything else is unmapped
  assign hit     = (haddr_in[31:5] == 27'h000_0000) && (haddr_in[1:0] == 2'h0)
                   && (idx < 3'(`IPR_NUM_REGS));

  // Remember a write until its data phase, when hwdata is on the bus
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend  <= 1'b0;
      wr_idx_q <= 3'h0;
    end else begin
      wr_pend  <= addr_ok && hwrite_in && hit;
      wr_idx_q <= idx;
    end
  end

  // Requests towards the bank
  assign bus.wr_en   = wr_pend;
  assign bus.wr_idx  = wr_idx_q;
  assign bus.rd_take = addr_ok && !hwrite_in;
  assign bus.rd_hit  = hit;
  assign bus.rd_idx  = idx;

endmodule : ipr_ahb_front

// ---- hdl/ipr_top.sv ----
// Interrupt priority bank: six priority registers, AHB-Lite slave, source gating
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "ipr_defines.svh"

// Functional notes
// - Three-bit level, 7 highest, 1 lowest
// - Level zero blocks the source entirely
// - Every field powers up at level four
// - Bits without a field read zero
// - Word 0: capture5, capture4, capture3, dma3
// - Word 1: compare6, compare5, capture6
// - Word 2: dma4 and parallel port
// - Word 3: i2c2 host and target
// - Word 4: crypto done, ext4, ext3
// - Word 5: spi2 rx, spi1 rx, key store
module ipr_top import ipr_pkg::*; #(
  parameter int ADDR_W = 32
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              hsel_in,
  input  wire logic [ADDR_W-1:0] haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic                   hreadyout_out,
  output logic      [31:0]       hrdata_out,
  output logic                   hresp_out,
  input  wire logic [16:0]       src_flag_in,
  output logic      [16:0]       src_req_out,
  output logic      [2:0]        capture5_irq_level_out,
  output logic      [2:0]        capture4_irq_level_out,
  output logic      [2:0]        capture3_irq_level_out,
  output logic      [2:0]        dma_ch3_irq_level_out,
  output logic      [2:0]        compare6_irq_level_out,
  output logic      [2:0]        compare5_irq_level_out,
  output logic      [2:0]        capture6_irq_level_out,
  output logic      [2:0]        dma_ch4_irq_level_out,
  output logic      [2:0]        parallel_port_irq_level_out,
  output logic      [2:0]        i2c2_host_irq_level_out,
  output logic      [2:0]        i2c2_target_irq_level_out,
  output logic      [2:0]        crypto_done_irq_level_out,
  output logic      [2:0]        ext_irq4_level_out,
  output logic      [2:0]        ext_irq3_level_out,
  output logic      [2:0]        spi2_receive_irq_level_out,
  output logic      [2:0]        spi1_receive_irq_level_out,
  output logic      [2:0]        key_store_done_irq_level_out
);

  // --------------------------------------------------------------------------
  // Register and field tables
  // --------------------------------------------------------------------------
  localparam int NREG = `IPR_NUM_REGS;
  localparam int NSRC = `IPR_NUM_SRC;

  localparam ipr_word_t MASK [NREG] = '{`IPR_MASK_0, `IPR_MASK_1, `IPR_MASK_2,
                                        `IPR_MASK_3, `IPR_MASK_4, `IPR_MASK_5};
  localparam ipr_word_t RSTV [NREG] = '{`IPR_RST_0, `IPR_RST_1, `IPR_RST_2,
                                        `IPR_RST_3, `IPR_RST_4, `IPR_RST_5};

  // Source order matches src_flag_in / src_req_out bit order
  localparam int FREG [NSRC] = '{0, 0, 0, 0,
                                 1, 1, 1,
                                 2, 2,
                                 3, 3,
                                 4, 4, 4,
                                 5, 5, 5};
  localparam int FLSB [NSRC] = '{`IPR_POS_HI, `IPR_POS_MID, `IPR_POS_LO1, `IPR_POS_LO0,
                                 `IPR_POS_MID, `IPR_POS_LO1, `IPR_POS_LO0,
                                 `IPR_POS_MID, `IPR_POS_LO1,
                                 `IPR_POS_MID, `IPR_POS_LO1,
                                 `IPR_POS_HI, `IPR_POS_MID, `IPR_POS_LO1,
                                 `IPR_POS_HI, `IPR_POS_MID, `IPR_POS_LO0};

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic rst_meta;
  logic rst_sync_n;

  // Asynchronous assert, release through two flops to avoid a ragged exit
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Bus front end
  // --------------------------------------------------------------------------
  ipr_regs_if bus ();

  ipr_ahb_front u_front (
    .clk_in    (core_clk_in),
    .rst_n_in  (rst_sync_n),
    .hsel_in   (hsel_in),
    .haddr_in  (32'(haddr_in)),
    .htrans_in (htrans_in),
    .hwrite_in (hwrite_in),
    .hready_in (hready_in),
    .bus       (bus.front)
  );

  // --------------------------------------------------------------------------
  // Priority registers
  // --------------------------------------------------------------------------
  ipr_word_t prio [NREG];

  // Write lands at the end of the data phase; masking drops unimplemented bits
  for (genvar r = 0; r < NREG; r++) begin : g_reg
    always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        prio[r] <= RSTV[r];
      end else if (bus.wr_en && (bus.wr_idx == 3'(r))) begin
        prio[r] <= hwdata_in[15:0] & MASK[r];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  ipr_word_t rd_word;

  // A read right behind a write to the same word sees the new value
  always_comb begin
    rd_word = 16'h0000;
    if (bus.rd_hit) begin
      if (bus.wr_en && (bus.wr_idx == bus.rd_idx)) begin
        rd_word = hwdata_in[15:0] & MASK[bus.rd_idx];
      end else begin
        rd_word = prio[bus.rd_idx];
      end
    end
  end

  // Data registered at the address phase so the data phase needs no wait
  always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hrdata_out <= 32'h0000_0000;
    end else if (bus.rd_take) begin
      hrdata_out <= {16'h0000, rd_word};
    end
  end

  // Zero-wait slave with OKAY only; unmapped reads return zero
  always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Per-source level and gating
  // --------------------------------------------------------------------------
  ipr_level_t lvl [NSRC];

  // Level zero keeps a source off whatever its flag; other codes pass it
  for (genvar s = 0; s < NSRC; s++) begin : g_src
    ipr_level_t fld;
    assign fld = prio[FREG[s]][FLSB[s] +: 3];
    always_ff @(posedge core_clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        lvl[s]         <= `IPR_LVL_RESET;
        src_req_out[s] <= 1'b0;
      end else begin
        lvl[s]         <= fld;
        src_req_out[s] <= src_flag_in[s] && (fld != `IPR_LVL_OFF);
      end
    end
  end

  // Level ports, each straight from its flop
  assign capture5_irq_level_out       = lvl[0];
  assign capture4_irq_level_out       = lvl[1];
  assign capture3_irq_level_out       = lvl[2];
  assign dma_ch3_irq_level_out        = lvl[3];
  assign compare6_irq_level_out       = lvl[4];
  assign compare5_irq_level_out       = lvl[5];
  assign capture6_irq_level_out       = lvl[6];
  assign dma_ch4_irq_level_out        = lvl[7];
  assign parallel_port_irq_level_out  = lvl[8];
  assign i2c2_host_irq_level_out      = lvl[9];
  assign i2c2_target_irq_level_out    = lvl[10];
  assign crypto_done_irq_level_out    = lvl[11];
  assign ext_irq4_level_out           = lvl[12];
  assign ext_irq3_level_out           = lvl[13];
  assign spi2_receive_irq_level_out   = lvl[14];
  assign spi1_receive_irq_level_out   = lvl[15];
  assign key_store_done_irq_level_out = lvl[16];

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_sync_n);

  // Address phases of interest
  sequence s_wr_addr(logic [31:0] off);
    hsel_in && htrans_in[1] && hready_in && hwrite_in && (32'(haddr_in) == off);
  endsequence

  sequence s_rd_addr(logic [31:0] off);
    hsel_in && htrans_in[1] && hready_in && !hwrite_in && (32'(haddr_in) == off);
  endsequence

  // Write of word 0 is visible one cycle after its data phase
  property p_write_word0;
    logic [15:0] d;
    s_wr_addr(`IPR_OFF_CAPTURE_DMA3) ##1 (1'b1, d = hwdata_in[15:0])
      |=> (prio[0] == (d & `IPR_MASK_0));
  endproperty
  a_write_word0 : assert property (p_write_word0) else $error("word 0 write lost");

  // Read of word 1 returns the stored word with zero upper half
  property p_read_word1;
    s_rd_addr(`IPR_OFF_COMPARE_CAP6) ##0 !bus.wr_en
      |=> (hrdata_out == {16'h0000, $past(prio[1])});
  endproperty
  a_read_word1 : assert property (p_read_word1) else $error("word 1 read mismatch");

  // Unimplemented positions of the key store word never become set
  property p_unimpl_zero;
    (prio[5] & ~`IPR_MASK_5) == 16'h0000 && hrdata_out[31:16] == 16'h0000;
  endproperty
  a_unimpl_zero : assert property (p_unimpl_zero) else $error("unimplemented bit set");

  // First cycle out of reset shows the capture5 and key store fields at level four
  // Watches the released copy so the first synchroniser stage keeps one reader
  property p_reset_levels;
    $rose(rst_sync_n) |-> ##1 (capture5_irq_level_out == `IPR_LVL_RESET)
      && (key_store_done_irq_level_out == `IPR_LVL_RESET);
  endproperty
  a_reset_levels : assert property (@(posedge core_clk_in) disable iff (!rst_n_in) p_reset_levels)
    else $error("level not four after reset");

  // Disabled source never requests, however long its flag stays up
  property p_disabled_blocks;
    (dma_ch4_irq_level_out == `IPR_LVL_OFF) && $stable(prio[2]) |-> !src_req_out[7];
  endproperty
  a_disabled_blocks : assert property (p_disabled_blocks) else $error("disabled source requested");

  // A flagged source with a non-zero level requests on the next edge
  property p_enabled_passes;
    src_flag_in[14] && (prio[5][14:12] >= `IPR_LVL_MIN) |=> src_req_out[14];
  endproperty
  a_enabled_passes : assert property (p_enabled_passes) else $error("enabled source dropped");

  // Field placement of words 0 to 5, checked for thirteen of the seventeen fields
  property p_pos_word0;
    capture5_irq_level_out == $past(prio[0][14:12]);
  endproperty
  a_pos_word0 : assert property (p_pos_word0) else $error("capture5 field misplaced");

  property p_pos_word1;
    capture6_irq_level_out == $past(prio[1][2:0]);
  endproperty
  a_pos_word1 : assert property (p_pos_word1) else $error("capture6 field misplaced");

  property p_pos_word2;
    parallel_port_irq_level_out == $past(prio[2][6:4]);
  endproperty
  a_pos_word2 : assert property (p_pos_word2) else $error("parallel field misplaced");

  property p_pos_word3;
    i2c2_host_irq_level_out == $past(prio[3][10:8]);
  endproperty
  a_pos_word3 : assert property (p_pos_word3) else $error("i2c2 host field misplaced");

  property p_pos_word4;
    crypto_done_irq_level_out == $past(prio[4][14:12]);
  endproperty
  a_pos_word4 : assert property (p_pos_word4) else $error("crypto field misplaced");

  property p_pos_word5;
    key_store_done_irq_level_out == $past(prio[5][2:0]);
  endproperty
  a_pos_word5 : assert property (p_pos_word5) else $error("key store field misplaced");

  property p_pos_capture4;
    capture4_irq_level_out == $past(prio[0][10:8]);
  endproperty
  a_pos_capture4 : assert property (p_pos_capture4) else $error("capture4 field misplaced");

  property p_pos_dma3;
    dma_ch3_irq_level_out == $past(prio[0][2:0]);
  endproperty
  a_pos_dma3 : assert property (p_pos_dma3) else $error("dma3 field misplaced");

  property p_pos_compare6;
    compare6_irq_level_out == $past(prio[1][10:8]);
  endproperty
  a_pos_compare6 : assert property (p_pos_compare6) else $error("compare6 field misplaced");

  property p_pos_dma4;
    dma_ch4_irq_level_out == $past(prio[2][10:8]);
  endproperty
  a_pos_dma4 : assert property (p_pos_dma4) else $error("dma4 field misplaced");

  property p_pos_i2c_target;
    i2c2_target_irq_level_out == $past(prio[3][6:4]);
  endproperty
  a_pos_i2c_target : assert property (p_pos_i2c_target) else $error("i2c2 target field misplaced");

  property p_pos_ext3;
    ext_irq3_level_out == $past(prio[4][6:4]);
  endproperty
  a_pos_ext3 : assert property (p_pos_ext3) else $error("ext3 field misplaced");

  property p_pos_spi1;
    spi1_receive_irq_level_out == $past(prio[5][10:8]);
  endproperty
  a_pos_spi1 : assert property (p_pos_spi1) else $error("spi1 receive field misplaced");

  // --------------------------------------------------------------------------
  // Per-word and per-source checks
  // --------------------------------------------------------------------------
  // Every word takes the masked data of its own data-phase strobe
  for (genvar r = 0; r < NREG; r++) begin : g_chk_reg
    property p_word_write;
      bus.wr_en && (bus.wr_idx == 3'(r)) |=> (prio[r] == ($past(hwdata_in[15:0]) & MASK[r]));
    endproperty
    a_word_write : assert property (p_word_write) else $error("masked write not stored");
  end

  // Level zero holds every source off; any other level lets its flag through
  for (genvar s = 0; s < NSRC; s++) begin : g_chk_src
    property p_src_off;
      (lvl[s] == `IPR_LVL_OFF) |-> !src_req_out[s];
    endproperty
    a_src_off : assert property (p_src_off) else $error("disabled source requested");

    property p_src_on;
      src_flag_in[s] ##1 (lvl[s] != `IPR_LVL_OFF) |-> src_req_out[s];
    endproperty
    a_src_on : assert property (p_src_on) else $error("enabled source dropped");
  end

  // Slave never stalls and never errors
  property p_bus_ok;
    hreadyout_out && !hresp_out;
  endproperty
  a_bus_ok : assert property (p_bus_ok) else $error("slave not ready or error");

endmodule : ipr_top

// ---- inc/ipr_defines.svh ----
// Offsets, field positions, masks, reset values and level codes of the priority bank
`ifndef IPR_DEFINES_SVH
`define IPR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets, one aligned word each
// ----------------------------------------------------------------------------
`define IPR_OFF_CAPTURE_DMA3    32'h0000_0000
`define IPR_OFF_COMPARE_CAP6    32'h0000_0004
`define IPR_OFF_DMA4_PARALLEL   32'h0000_0008
`define IPR_OFF_SECOND_I2C      32'h0000_000C
`define IPR_OFF_CRYPTO_EXTINT   32'h0000_0010
`define IPR_OFF_SPI_RX_KEYSTORE 32'h0000_0014
`define IPR_NUM_REGS            6
`define IPR_NUM_SRC             17

// ----------------------------------------------------------------------------
// Implemented-bit masks and power-on values
// ----------------------------------------------------------------------------
`define IPR_MASK_0 16'h7777
`define IPR_MASK_1 16'h0777
`define IPR_MASK_2 16'h0770
`define IPR_MASK_3 16'h0770
`define IPR_MASK_4 16'h7770
`define IPR_MASK_5 16'h7707
`define IPR_RST_0  16'h4444
`define IPR_RST_1  16'h0444
`define IPR_RST_2  16'h0440
`define IPR_RST_3  16'h0440
`define IPR_RST_4  16'h4440
`define IPR_RST_5  16'h4404

// ----------------------------------------------------------------------------
// Field least significant bit positions
// ----------------------------------------------------------------------------
`define IPR_POS_HI  12
`define IPR_POS_MID 8
`define IPR_POS_LO1 4
`define IPR_POS_LO0 0

// ----------------------------------------------------------------------------
// Level codes
// ----------------------------------------------------------------------------
`define IPR_LVL_OFF   3'h0
`define IPR_LVL_MIN   3'h1
`define IPR_LVL_RESET 3'h4
`define IPR_LVL_MAX   3'h7

`endif

// ---- inc/ipr_pkg.sv ----
// Types shared by the priority bank modules
package ipr_pkg;

  // --------------------------------------------------------------------------
  // Bus and register types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    IPR_TR_IDLE   = 2'h0,
    IPR_TR_BUSY   = 2'h1,
    IPR_TR_NONSEQ = 2'h2,
    IPR_TR_SEQ    = 2'h3
  } ipr_htrans_t;

  typedef logic [2:0]  ipr_level_t;
  typedef logic [2:0]  ipr_idx_t;
  typedef logic [15:0] ipr_word_t;

endpackage : ipr_pkg

// ---- inc/ipr_regs_if.sv ----
// Request carrier between the bus front end and the register bank
`timescale 1ns/1ps
interface ipr_regs_if;
  import ipr_pkg::*;
  logic     wr_en;    // Data-phase write strobe
  logic     [2:0] wr_idx;
  logic     rd_take;  // Read address phase accepted
  logic     rd_hit;   // Read hits a mapped register
  logic     [2:0] rd_idx;

  modport front (output wr_en, wr_idx, rd_take, rd_hit, rd_idx);
  modport bank  (input  wr_en, wr_idx, rd_take, rd_hit, rd_idx);
endinterface : ipr_regs_if

// ---- tb/ipr_periph_model.sv ----
// Behavioural model of the peripherals that raise request flags into the priority bank
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Each peripheral holds its flag as a level until the bench drops it
// ----------------------------------------------------------------------------
module ipr_periph_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [16:0] pattern_in,
  output logic      [16:0] src_flag_out
);
  // Flags change just after an edge, like a real synchronous peripheral
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_flag_out <= 17'h0_0000;
    end else begin
      src_flag_out <= pattern_in;
    end
  end
endmodule : ipr_periph_model

// ---- tb/tb.sv ----
// Self-checking bench for the interrupt priority bank
`timescale 1ns/1ps
`include "ipr_defines.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

module tb import ipr_pkg::*; ;
  // --------------------------------------------------------------------------
  // Signals and reference model
  // --------------------------------------------------------------------------
  logic        core_clk;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [16:0] pat;
  logic [16:0] flag;
  logic [16:0] req;
  logic [2:0]  lvl [17];
  logic [15:0] regm [6];
  logic [15:0] mask [6] = '{`IPR_MASK_0, `IPR_MASK_1, `IPR_MASK_2, `IPR_MASK_3, `IPR_MASK_4, `IPR_MASK_5};
  logic [31:0] off [6] = '{`IPR_OFF_CAPTURE_DMA3, `IPR_OFF_COMPARE_CAP6, `IPR_OFF_DMA4_PARALLEL,
                           `IPR_OFF_SECOND_I2C, `IPR_OFF_CRYPTO_EXTINT, `IPR_OFF_SPI_RX_KEYSTORE};
  logic [31:0] bad [5] = '{32'h0000_0018, 32'h0000_001C, 32'h0000_0002, 32'h0000_0100, 32'h8000_0004};
  // Word and field position of each source, in src_req bit order
  int          sw [17] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 3, 3, 4, 4, 4, 5, 5, 5};
  int          sp [17] = '{12, 8, 4, 0, 8, 4, 0, 8, 4, 8, 4, 12, 8, 4, 12, 8, 0};
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [31:0] junk;

  // --------------------------------------------------------------------------
  // Design, peripheral model and clock
  // --------------------------------------------------------------------------
  ipr_top i_dut (
    .core_clk_in(core_clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hrdata_out(hrdata), .hresp_out(hresp), .src_flag_in(flag), .src_req_out(req),
    .capture5_irq_level_out(lvl[0]), .capture4_irq_level_out(lvl[1]), .capture3_irq_level_out(lvl[2]),
    .dma_ch3_irq_level_out(lvl[3]), .compare6_irq_level_out(lvl[4]), .compare5_irq_level_out(lvl[5]),
    .capture6_irq_level_out(lvl[6]), .dma_ch4_irq_level_out(lvl[7]), .parallel_port_irq_level_out(lvl[8]),
    .i2c2_host_irq_level_out(lvl[9]), .i2c2_target_irq_level_out(lvl[10]),
    .crypto_done_irq_level_out(lvl[11]), .ext_irq4_level_out(lvl[12]), .ext_irq3_level_out(lvl[13]),
    .spi2_receive_irq_level_out(lvl[14]), .spi1_receive_irq_level_out(lvl[15]),
    .key_store_done_irq_level_out(lvl[16])
  );

  ipr_periph_model i_periph (
    .clk_in      (core_clk),
    .rst_n_in    (rst_n),
    .pattern_in  (pat),
    .src_flag_out(flag)
  );

  // 20 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // --------------------------------------------------------------------------
  // Bus master tasks, entered just after a rising edge
  // --------------------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= IPR_TR_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    // Address phase held until hready is seen high; the timeout cuts a hang
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= IPR_TR_IDLE;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask : ahb

  // Write and mirror into the model; unimplemented bits and unmapped places drop the data
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, junk);
    for (int k = 0; k < 6; k++) begin
      if (off[k] == a) regm[k] = d[15:0] & mask[k];
    end
  endtask : wr_reg

  task automatic rd_chk(input logic [31:0] a);
    logic [31:0] exp;
    logic [31:0] got;
    exp = 32'h0000_0000;
    for (int k = 0; k < 6; k++) begin
      if (off[k] == a) exp = {16'h0000, regm[k]};
    end
    ahb(1'b0, a, 32'($urandom), got);
    `CHK(got, exp)
  endtask : rd_chk

  // Every register, every level port and every gated request against the model
  task automatic check_all;
    logic [2:0] e;
    for (int k = 0; k < 6; k++) rd_chk(off[k]);
    repeat (2) @(posedge core_clk);
    for (int s = 0; s < 17; s++) begin
      e = 3'((regm[sw[s]] >> sp[s]) & 16'h0007);
      `CHK(lvl[s], e)
      `CHK(req[s], pat[s] && e != 3'h0)
    end
  endtask : check_all

  // --------------------------------------------------------------------------
  // Verdict and hang guard
  // --------------------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Whole run is under six hundred cycles; the ceiling leaves ample margin
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    rst_n  = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = IPR_TR_IDLE;
    hwrite = 1'b0;
    hsize  = 3'h0;
    hwdata = 32'h0000_0000;
    pat    = 17'h1_FFFF;
    void'($urandom(32'h3ffb3647));
    for (int k = 0; k < 6; k++) regm[k] = 16'h4444 & mask[k];
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    check_all();
    // Every level code in every field, gap bits and upper half written as ones
    for (int v = 0; v < 8; v++) begin
      for (int k = 0; k < 6; k++) wr_reg(off[k], {16'hFFFF, {4{1'b1, 3'(v)}}});
      check_all();
    end
    // Random data and flags, each write read straight back
    repeat (16) begin
      pat <= 17'($urandom);
      wr_reg(off[$urandom_range(5, 0)], $urandom);
      check_all();
    end
    // Unmapped places take nothing and read zero
    for (int b = 0; b < 5; b++) begin
      wr_reg(bad[b], 32'hFFFF_FFFF);
      rd_chk(bad[b]);
    end
    check_all();
    // Second reset in mid-run brings every field back to level four
    rst_n <= 1'b0;
    for (int k = 0; k < 6; k++) regm[k] = 16'h4444 & mask[k];
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    check_all();
    print_verdict();
  end
endmodule : tb
